/* File: rtl/circ_ptr_step.sv */
// next value of one data pointer for an increment or decrement
// assumes length and enable are the live register values of this cycle
`timescale 1ns/1ns
module circ_ptr_step
  import dsp_addr_pkg::*;
(
  // current state
  input  wire logic [dsp_addr_pkg::PTR_W-1:0]  ptr,
  input  wire logic [dsp_addr_pkg::DATA_W-1:0] len,
  input  wire logic                            circ_en,
  input  wire logic                            dec,
  // result
  output      logic [dsp_addr_pkg::PTR_W-1:0]  next_ptr
);

  wire [PTR_W-1:0] len_w   = {{(PTR_W-DATA_W){1'b0}}, len};
  wire [PTR_W-1:0] a_top   = BUF_A_BASE + len_w; // R5
  wire [PTR_W-1:0] b_top   = BUF_B_BASE + len_w; // R5
  // offset compare: a pointer below a base wraps high and misses that region
  wire             in_a    = (ptr - BUF_A_BASE) <= len_w; // R6
  wire             in_b    = (ptr - BUF_B_BASE) <= len_w; // R6
  wire             wrap_up = circ_en && !dec && ((in_a && ptr == a_top) || (in_b && ptr == b_top));
  wire             wrap_dn = circ_en && dec && (ptr == BUF_A_BASE || ptr == BUF_B_BASE);
  wire [PTR_W-1:0] lin     = dec ? ptr - PTR_STEP : ptr + PTR_STEP; // R10
  wire [PTR_W-1:0] base    = in_b ? BUF_B_BASE : BUF_A_BASE;
  wire [PTR_W-1:0] top     = in_b ? b_top : a_top;

  // wrap only at the region edges, linear everywhere else
  assign next_ptr = wrap_up ? base : (wrap_dn ? top : lin); // R7 R8 R17

endmodule

/* File: rtl/dsp_addr_pkg.sv */
// constants, register map and operation codes for the pointer addressing block
// assumes one core clock; shared by the block and its wrap stepper
package dsp_addr_pkg;

  // bus and register map (printed offsets are word indices)
  localparam int          ADDR_W        = 12;
  localparam int          IDX_LSB       = 2;
  localparam int          IDX_MSB       = 9;
  localparam logic [7:0]  IDX_CONFIG    = 8'he2;
  localparam logic [7:0]  IDX_LENGTH    = 8'he3;
  localparam logic [7:0]  IDX_PTR_VIEW  = 8'he8;
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;
  localparam logic [7:0]  LENGTH_RESET  = 8'h00;
  localparam logic [15:0] PTR_RESET     = 16'h0000;

  // config field positions
  localparam int BIT_REDIRECT = 0;
  localparam int BIT_IDX_DIS  = 1;
  localparam int BIT_CIRC_A   = 2;
  localparam int BIT_CIRC_B   = 3;
  localparam int BIT_SIGN_A   = 4;
  localparam int BIT_SIGN_B   = 5;

  // addressing constants
  localparam int          PTR_W         = 16;
  localparam int          DATA_W        = 8;
  localparam int          PTR_COUNT     = 2;
  localparam logic [7:0]  PREFIX_OPCODE = 8'ha5;
  localparam logic [15:0] BUF_A_BASE    = 16'h0000;
  localparam logic [15:0] BUF_B_BASE    = 16'h0100;
  localparam logic [15:0] PTR_STEP      = 16'h0001;

  typedef enum logic [2:0]
  {
    OP_NONE,
    OP_LOAD,
    OP_INC,
    OP_AUTO,
    OP_MOVC,
    OP_MOVX,
    OP_JMP
  } ptr_op_e;

endpackage

/* File: rtl/dsp_addressing.sv */
// dual data pointer addressing extensions: signed multiply, circular buffers,
// code-read index disable, second-pointer redirect and pointer-swap prefix
// assumes the core presents one instruction per instr_valid pulse, AHB-Lite
// single word transfers from one master, and a 100 MHz hclk
//
// Function
// R1: multiply treats B as signed when its signedness bit is set, else unsigned
// R2: multiply treats accumulator as signed when its signedness bit is set
// R3: two independent enable bits put pointer a and pointer b into circular mode
// R4: buffer length comes from the 8-bit length register, up to 256 entries
// R5: buffer A spans 0000H to length; buffer B spans 0100H to 0100H plus length
// R6: a circular pointer wraps within whichever region it currently lies in
// R7: increment at a region top wraps to that region's base
// R8: decrement at a region base wraps to that region's top
// R9: wrapping covers explicit increments and auto updates, auto direction per pointer
// R10: outside both regions a circular pointer steps linearly over 16 bits
// R11: index-disable bit makes the code read use the pointer without accumulator
// R12: redirect bit makes second-pointer code and xdata moves use B, not accumulator
// R13: redirect never changes the code read index, which stays the accumulator
// R14: prefix opcode makes the next pointer instruction use the inverted select
// R15: indirect jump through the pointer ignores the prefix inversion
// R16: prefix affects only the next instruction; the select bit stays unchanged
// R17: wrap compare uses the length value current at each update
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
module dsp_addressing
  import dsp_addr_pkg::*;
(
  // clock and reset
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [dsp_addr_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output      logic                             hreadyout,
  output      logic [31:0]                      hrdata,
  output      logic                             hresp,
  // instruction from the core
  input  wire logic                             instr_valid,
  input  wire logic [7:0]                       instr_opcode,
  input  wire dsp_addr_pkg::ptr_op_e            instr_op,
  input  wire logic                             pointer_select,
  input  wire logic [1:0]                       pointer_update_direction,
  input  wire logic [dsp_addr_pkg::PTR_W-1:0]   load_value,
  input  wire logic [dsp_addr_pkg::DATA_W-1:0]  acc,
  input  wire logic [dsp_addr_pkg::DATA_W-1:0]  b_reg,
  // multiply request
  input  wire logic                             mul_req,
  // pointer state
  output      logic [dsp_addr_pkg::PTR_W-1:0]   data_pointer_a,
  output      logic [dsp_addr_pkg::PTR_W-1:0]   data_pointer_b,
  // per-instruction answers
  output      logic                             op_done,
  output      logic                             ptr_sel_used,
  output      logic [dsp_addr_pkg::PTR_W-1:0]   mem_addr,
  output      logic                             xfer_use_b,
  output      logic                             mul_done,
  output      logic [2*dsp_addr_pkg::DATA_W-1:0] mul_product
);

  // registers and pointer storage
  logic [7:0]       dsp_addressing_config;
  logic [7:0]       circular_buffer_length;
  logic [PTR_W-1:0] dptr [PTR_COUNT];
  logic             prefix_pending;
  logic             wr_pend;
  logic [7:0]       wr_idx;

  // single decode of an index against a word address
  function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] target);
    idx_hit = (idx == target);
  endfunction

  // bus decode
  wire [7:0] addr_idx   = haddr[IDX_MSB:IDX_LSB];
  wire       addr_phase = hsel && htrans[1] && hready;
  wire       wr_cfg     = wr_pend && idx_hit(wr_idx, IDX_CONFIG);
  wire       wr_len     = wr_pend && idx_hit(wr_idx, IDX_LENGTH);

  // read bypass so a read right after a write sees the new value
  wire [7:0] cfg_now = wr_cfg ? hwdata[7:0] : dsp_addressing_config;
  wire [7:0] len_now = wr_len ? hwdata[7:0] : circular_buffer_length;

  wire [31:0] read_mux =
    idx_hit(addr_idx, IDX_CONFIG)   ? {24'h000000, cfg_now} :
    idx_hit(addr_idx, IDX_LENGTH)   ? {24'h000000, len_now} :
    idx_hit(addr_idx, IDX_PTR_VIEW) ? {dptr[1], dptr[0]} :
    32'h00000000;

  // config fields
  wire redirect   = dsp_addressing_config[BIT_REDIRECT];
  wire idx_dis    = dsp_addressing_config[BIT_IDX_DIS];
  wire mul_a_sign = dsp_addressing_config[BIT_SIGN_A];
  wire mul_b_sign = dsp_addressing_config[BIT_SIGN_B];
  wire [PTR_COUNT-1:0] circ_en =
    {dsp_addressing_config[BIT_CIRC_B], dsp_addressing_config[BIT_CIRC_A]}; // R3

  // pointer selection for this instruction
  wire is_prefix = instr_valid && (instr_opcode == PREFIX_OPCODE);
  wire is_jmp    = (instr_op == OP_JMP);
  wire sel_eff   = pointer_select ^ (prefix_pending && !is_jmp); // R14 R15
  wire [PTR_W-1:0] sel_ptr = sel_eff ? dptr[1] : dptr[0];
  wire [PTR_W-1:0] acc_w   = {{(PTR_W-DATA_W){1'b0}}, acc};

  // code read index: disable drops the accumulator, redirect never touches it
  wire [PTR_W-1:0] movc_addr = idx_dis ? sel_ptr : sel_ptr + acc_w; // R11 R13
  wire [PTR_W-1:0] jmp_addr  = sel_ptr + acc_w;
  wire [PTR_W-1:0] next_addr =
    (instr_op == OP_MOVC) ? movc_addr :
    (instr_op == OP_JMP)  ? jmp_addr  : sel_ptr;
  wire next_use_b = redirect && sel_eff &&
                    (instr_op == OP_MOVC || instr_op == OP_MOVX); // R12

  // operand extension picks signed or unsigned per bit
  wire signed [DATA_W:0]     mul_a_ext = {mul_a_sign & acc[DATA_W-1], acc};     // R2
  wire signed [DATA_W:0]     mul_b_ext = {mul_b_sign & b_reg[DATA_W-1], b_reg}; // R1
  wire signed [2*DATA_W+1:0] mul_full  = mul_a_ext * mul_b_ext;

  // pointer stepping, one stepper per pointer
  logic [PTR_W-1:0] step_next [PTR_COUNT];
  logic [PTR_W-1:0] next_dptr [PTR_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < PTR_COUNT; gi++)
    begin : g_ptr
      wire this_sel = instr_valid && !is_prefix && (sel_eff == 1'(gi));
      wire step_dec = (instr_op == OP_AUTO) && pointer_update_direction[gi]; // R9

      circ_ptr_step u_step
      (
        .ptr      (dptr[gi]),
        .len      (circular_buffer_length), // R4 R17
        .circ_en  (circ_en[gi]),
        .dec      (step_dec),
        .next_ptr (step_next[gi])
      );

      assign next_dptr[gi] =
        (this_sel && instr_op == OP_LOAD) ? load_value :
        (this_sel && (instr_op == OP_INC || instr_op == OP_AUTO)) ? step_next[gi] :
        dptr[gi]; // R3 R9

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          dptr[gi] <= PTR_RESET;
        else
          dptr[gi] <= next_dptr[gi];
      end
    end
  endgenerate

  // bus slave; zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_idx    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend   <= addr_phase && hwrite;
      wr_idx    <= addr_phase ? addr_idx : wr_idx;
      hrdata    <= (addr_phase && !hwrite) ? read_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dsp_addressing_config  <= CONFIG_RESET;
      circular_buffer_length <= LENGTH_RESET;
    end
    else
    begin
      dsp_addressing_config  <= cfg_now;
      circular_buffer_length <= len_now; // R4
    end
  end

  // prefix holds for exactly one following instruction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prefix_pending <= 1'b0;
    else if (instr_valid)
      prefix_pending <= is_prefix; // R16
  end

  // per-instruction answers, one cycle after the request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_done      <= 1'b0;
      ptr_sel_used <= 1'b0;
      mem_addr     <= PTR_RESET;
      xfer_use_b   <= 1'b0;
      mul_done     <= 1'b0;
      mul_product  <= 16'h0000;
    end
    else
    begin
      op_done      <= instr_valid && !is_prefix && instr_op != OP_NONE;
      ptr_sel_used <= (instr_valid && !is_prefix) ? sel_eff : ptr_sel_used;
      mem_addr     <= (instr_valid && !is_prefix) ? next_addr : mem_addr;
      xfer_use_b   <= instr_valid && !is_prefix && next_use_b;
      mul_done     <= mul_req;
      mul_product  <= mul_req ? mul_full[2*DATA_W-1:0] : mul_product; // R1 R2
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire real_op = instr_valid && !is_prefix && instr_op != OP_NONE;

  // the core leaves at least one idle cycle between instruction bytes
  sequence s_prefix_then_op;
    is_prefix ##1 !instr_valid ##1 (real_op && !is_jmp);
  endsequence

  sequence s_prefix_then_jmp;
    is_prefix ##1 !instr_valid ##1 (real_op && is_jmp);
  endsequence

  a_prefix_inverts: assert property // R14
    (s_prefix_then_op |=> ptr_sel_used == !$past(pointer_select))
    else $error("prefix did not invert the pointer select");

  a_jmp_no_invert: assert property // R15
    (s_prefix_then_jmp |=> ptr_sel_used == $past(pointer_select))
    else $error("indirect jump took the inverted select");

  a_prefix_one_shot: assert property // R16
    (real_op ##1 !instr_valid ##1 real_op |=> ptr_sel_used == $past(pointer_select))
    else $error("prefix effect outlived one instruction");

  a_prefix_quiet: assert property // R16
    (is_prefix |=> $stable(ptr_sel_used) && $stable(data_pointer_a) && $stable(data_pointer_b))
    else $error("prefix byte changed pointer state");

  a_wrap_inc_top: assert property // R7
    (real_op && instr_op == OP_INC && circ_en[sel_eff] &&
     sel_ptr == {8'h00, circular_buffer_length}
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) == BUF_A_BASE)
    else $error("increment at buffer a top did not wrap");

  a_wrap_inc_b_top: assert property // R7
    (real_op && instr_op == OP_INC && circ_en[sel_eff] &&
     sel_ptr == BUF_B_BASE + {8'h00, circular_buffer_length}
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) == BUF_B_BASE)
    else $error("increment at buffer b top did not wrap");

  a_wrap_dec_a_base: assert property // R8
    (real_op && instr_op == OP_AUTO && circ_en[sel_eff] &&
     pointer_update_direction[sel_eff] && sel_ptr == BUF_A_BASE
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) ==
         {8'h00, $past(circular_buffer_length)})
    else $error("decrement at buffer a base did not wrap");

  a_circ_off_linear: assert property // R3
    (real_op && instr_op == OP_INC && !circ_en[sel_eff]
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) == $past(sel_ptr) + PTR_STEP)
    else $error("pointer stepped circularly with its mode off");

  a_auto_linear_dn: assert property // R9 R10
    (real_op && instr_op == OP_AUTO && pointer_update_direction[sel_eff] &&
     sel_ptr > BUF_B_BASE + {8'h00, circular_buffer_length}
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) == $past(sel_ptr) - PTR_STEP)
    else $error("auto decrement above buffer b not linear");

  a_wrap_dec_base: assert property // R8
    (real_op && instr_op == OP_AUTO && circ_en[sel_eff] &&
     pointer_update_direction[sel_eff] && sel_ptr == BUF_B_BASE
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) ==
         BUF_B_BASE + {8'h00, $past(circular_buffer_length)})
    else $error("decrement at buffer b base did not wrap");

  a_linear_gap: assert property // R10
    (real_op && instr_op == OP_INC && sel_ptr[15:8] == 8'h00 &&
     sel_ptr[7:0] > circular_buffer_length && sel_ptr[7:0] != 8'hff
     |=> (ptr_sel_used ? data_pointer_b : data_pointer_a) == $past(sel_ptr) + PTR_STEP)
    else $error("pointer in the gap did not step linearly");

  a_idx_disabled: assert property // R11
    (real_op && instr_op == OP_MOVC && idx_dis |=> mem_addr == $past(sel_ptr))
    else $error("code read index not disabled");

  a_idx_kept_acc: assert property // R13
    (real_op && instr_op == OP_MOVC && !idx_dis && redirect
     |=> mem_addr == $past(sel_ptr) + {8'h00, $past(acc)})
    else $error("redirect disturbed the code read index");

  a_redirect_b: assert property // R12
    (real_op && instr_op == OP_MOVX |=> xfer_use_b == ($past(redirect) && ptr_sel_used))
    else $error("redirect to b wrong for data move");

  a_redirect_movc: assert property // R12 R13
    (real_op && instr_op == OP_MOVC |=> xfer_use_b == ($past(redirect) && ptr_sel_used))
    else $error("redirect to b wrong for code read");

  a_mul_signed: assert property // R1 R2
    (mul_req && mul_a_sign && mul_b_sign |=> mul_done &&
     $signed(mul_product) == $signed($past(acc)) * $signed($past(b_reg)))
    else $error("signed multiply result wrong");

  a_mul_unsigned: assert property // R1 R2
    (mul_req && !mul_a_sign && !mul_b_sign
     |=> mul_product == $past(acc) * $past(b_reg))
    else $error("unsigned multiply result wrong");

  a_mul_a_signed: assert property // R2
    (mul_req && mul_a_sign && !mul_b_sign
     |=> $signed(mul_product) == $signed($past(acc)) * $signed({1'b0, $past(b_reg)}))
    else $error("signed accumulator multiply wrong");

  a_mul_b_signed: assert property // R1
    (mul_req && !mul_a_sign && mul_b_sign
     |=> $signed(mul_product) == $signed({1'b0, $past(acc)}) * $signed($past(b_reg)))
    else $error("signed b multiply wrong");

  a_other_ptr_kept: assert property // R3
    (real_op && instr_op == OP_INC && !sel_eff |=> $stable(data_pointer_b))
    else $error("pointer b moved on a pointer a update");

  // outputs
  assign data_pointer_a = dptr[0];
  assign data_pointer_b = dptr[1];

endmodule

/* File: tb/core_model.sv */
// core-side model: issues instructions, prefix bytes and multiplies
// assumes the block samples its instruction inputs on the rising hclk edge
`timescale 1ns/1ns
module core_model
  import dsp_addr_pkg::*;
(
  // clock
  input  wire logic                   hclk,
  // instruction port
  output      logic                   instr_valid,
  output      logic [7:0]             instr_opcode,
  output      dsp_addr_pkg::ptr_op_e  instr_op,
  output      logic                   pointer_select,
  output      logic [1:0]             pointer_update_direction,
  output      logic [15:0]            load_value,
  output      logic [7:0]             acc,
  output      logic [7:0]             b_reg,
  output      logic                   mul_req
);
  initial
  begin
    instr_valid = 1'h0;
    instr_opcode = 8'h00;
    instr_op = OP_NONE;
    pointer_select = 1'h0;
    pointer_update_direction = 2'h0;
    load_value = 16'h0000;
    acc = 8'h00;
    b_reg = 8'h00;
    mul_req = 1'h0;
  end

  // gap lets a prefix sit idle before its instruction
  task automatic issue(input logic [7:0] opc, input ptr_op_e op, input logic sel,
                       input logic [15:0] val, input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    instr_valid <= 1'h1;
    instr_opcode <= opc;
    instr_op <= op;
    pointer_select <= sel;
    load_value <= val;
    @(posedge hclk);
    instr_valid <= 1'h0;
    instr_op <= OP_NONE;
    load_value <= ~val;
  endtask

  task automatic set_regs(input logic [7:0] a, input logic [7:0] b, input logic [1:0] dir);
    @(posedge hclk);
    acc <= a;
    b_reg <= b;
    pointer_update_direction <= dir;
  endtask

  task automatic mul(input logic [7:0] a, input logic [7:0] b);
    @(posedge hclk);
    acc <= a;
    b_reg <= b;
    mul_req <= 1'h1;
    @(posedge hclk);
    mul_req <= 1'h0;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench: ahb-lite register tasks plus core instruction sequences
// assumes a zero-or-more wait state slave and the core_model partner
`timescale 1ns/1ns
module testbench;
  import dsp_addr_pkg::*;
  localparam logic [11:0] A_CFG = 12'({IDX_CONFIG, 2'h0});
  localparam logic [11:0] A_LEN = 12'({IDX_LENGTH, 2'h0});
  localparam logic [11:0] A_BAD = 12'h3fc;
  localparam logic [11:0] A_VIEW = 12'({IDX_PTR_VIEW, 2'h0});
  localparam logic [31:0] CA = 32'h1 << BIT_CIRC_A;
  localparam logic [31:0] CB = 32'h1 << BIT_CIRC_B;
  localparam logic [31:0] RD = 32'h1 << BIT_REDIRECT;
  localparam logic [31:0] ID = 32'h1 << BIT_IDX_DIS;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic        hreadyout, hresp, instr_valid, pointer_select, mul_req;
  logic        op_done, ptr_sel_used, xfer_use_b, mul_done;
  logic [31:0] hrdata;
  logic [7:0]  instr_opcode, acc, b_reg;
  logic [1:0]  dir;
  logic [15:0] load_value, data_pointer_a, data_pointer_b, mem_addr, mul_product;
  ptr_op_e     instr_op;
  int          mismatches = 0;
  int          total_checks = 0;
  int          pa, pb;
  logic [31:0] sgn;

  always #5 hclk = ~hclk;

  core_model u_core (.hclk(hclk), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_op(instr_op), .pointer_select(pointer_select), .pointer_update_direction(dir),
    .load_value(load_value), .acc(acc), .b_reg(b_reg), .mul_req(mul_req));

  dsp_addressing uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_op(instr_op), .pointer_select(pointer_select),
    .pointer_update_direction(dir), .load_value(load_value), .acc(acc), .b_reg(b_reg),
    .mul_req(mul_req), .data_pointer_a(data_pointer_a), .data_pointer_b(data_pointer_b),
    .op_done(op_done), .ptr_sel_used(ptr_sel_used), .mem_addr(mem_addr),
    .xfer_use_b(xfer_use_b), .mul_done(mul_done), .mul_product(mul_product));

  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // hready is sampled before the edge's own updates land
  task automatic rdy;
    @(posedge hclk);
    while (hreadyout !== 1'h1)
      @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~wd;
    rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic step(input ptr_op_e op, input logic sel, input logic [15:0] val);
    u_core.issue(8'h00, op, sel, val, 0);
    #1;
  endtask

  task automatic pstep(input logic sel, input logic [15:0] start, input ptr_op_e op,
                       input logic dec, input logic [15:0] expv);
    u_core.set_regs(8'h00, 8'h00, {dec, dec});
    step(OP_LOAD, sel, start);
    step(op, sel, 16'h0000);
    chk({15'h0, op_done, sel ? data_pointer_b : data_pointer_a}, {15'h0, 1'h1, expv});
  endtask

  initial
  begin
    #50000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdchk(A_CFG, {24'h0, CONFIG_RESET});
    bus(1'h1, A_BAD, 32'h5a);
    rdchk(A_BAD, 32'h0);
    bus(1'h1, A_CFG, 32'hffffffff);
    rdchk(A_CFG, 32'hff);
    bus(1'h1, A_LEN, 32'h5);
    rdchk(A_LEN, 32'h5);
    bus(1'h1, A_CFG, CA | CB);
    pstep(1'h0, 16'h0005, OP_INC, 1'h0, BUF_A_BASE);
    pstep(1'h0, 16'h0000, OP_AUTO, 1'h1, 16'h0005);
    pstep(1'h1, 16'h0105, OP_INC, 1'h0, BUF_B_BASE);
    pstep(1'h1, 16'h0100, OP_AUTO, 1'h1, 16'h0105);
    pstep(1'h0, 16'h0105, OP_AUTO, 1'h0, BUF_B_BASE);
    pstep(1'h1, 16'h0005, OP_AUTO, 1'h0, BUF_A_BASE);
    pstep(1'h0, 16'h0006, OP_INC, 1'h0, 16'h0007);
    pstep(1'h0, 16'h0106, OP_AUTO, 1'h1, 16'h0105);
    pstep(1'h1, 16'h0006, OP_AUTO, 1'h1, 16'h0005);
    bus(1'h1, A_CFG, CA);
    pstep(1'h1, 16'h0105, OP_INC, 1'h0, 16'h0106);
    pstep(1'h0, 16'h0105, OP_INC, 1'h0, BUF_B_BASE);
    bus(1'h1, A_LEN, 32'h10);
    pstep(1'h0, 16'h0005, OP_INC, 1'h0, 16'h0006);
    pstep(1'h0, 16'h0110, OP_INC, 1'h0, BUF_B_BASE);
    bus(1'h1, A_LEN, 32'hff);
    pstep(1'h0, 16'h00ff, OP_INC, 1'h0, BUF_A_BASE);
    bus(1'h1, A_CFG, 32'h0);
    step(OP_LOAD, 1'h0, 16'h0010);
    step(OP_LOAD, 1'h1, 16'h0020);
    u_core.issue(PREFIX_OPCODE, OP_NONE, 1'h0, 16'h0000, 3);
    step(OP_INC, 1'h0, 16'h0000);
    chk({data_pointer_b, data_pointer_a}, 32'h00210010);
    chk({31'h0, ptr_sel_used}, 32'h1);
    step(OP_INC, 1'h0, 16'h0000);
    chk({data_pointer_b, data_pointer_a}, 32'h00210011);
    chk({31'h0, ptr_sel_used}, 32'h0);
    rdchk(A_VIEW, 32'h00210011);
    u_core.set_regs(8'h04, 8'h00, 2'h0);
    u_core.issue(PREFIX_OPCODE, OP_NONE, 1'h0, 16'h0000, 0);
    step(OP_JMP, 1'h0, 16'h0000);
    chk({15'h0, ptr_sel_used, mem_addr}, 32'h00000015);
    bus(1'h1, A_CFG, RD);
    u_core.set_regs(8'h03, 8'h00, 2'h0);
    step(OP_MOVC, 1'h1, 16'h0000);
    chk({15'h0, xfer_use_b, mem_addr}, 32'h00010024);
    step(OP_MOVC, 1'h0, 16'h0000);
    chk({15'h0, xfer_use_b, mem_addr}, 32'h00000014);
    bus(1'h1, A_CFG, RD | ID);
    step(OP_MOVC, 1'h1, 16'h0000);
    chk({15'h0, xfer_use_b, mem_addr}, 32'h00010021);
    u_core.issue(PREFIX_OPCODE, OP_NONE, 1'h0, 16'h0000, 0);
    step(OP_MOVX, 1'h0, 16'h0000);
    chk({31'h0, xfer_use_b}, 32'h1);
    bus(1'h1, A_CFG, 32'h0);
    step(OP_MOVX, 1'h1, 16'h0000);
    chk({31'h0, xfer_use_b}, 32'h0);
    step(OP_MOVC, 1'h0, 16'h0000);
    chk({16'h0, mem_addr}, 32'h00000014);
    for (int i = 0; i < 4; i++)
    begin
      sgn = (i[0] ? (32'h1 << BIT_SIGN_A) : 32'h0) | (i[1] ? (32'h1 << BIT_SIGN_B) : 32'h0);
      bus(1'h1, A_CFG, sgn);
      pa = i[0] ? int'($signed(8'hff)) : 255;
      pb = i[1] ? int'($signed(8'hfe)) : 254;
      u_core.mul(8'hff, 8'hfe);
      #1;
      chk({14'h0, hresp, mul_done, mul_product}, {14'h0, 1'h0, 1'h1, 16'(pa * pb)});
    end
    end_sim();
  end
endmodule
